//--- cpu_flag_map.vh
// Constants for the status-flag core: register offsets, flag positions,
// reset values, instruction codes and cycle counts.
// Assumes it is included by bare name from each design file that needs it.
`ifndef CPU_FLAG_MAP_VH
`define CPU_FLAG_MAP_VH

// ==========================================================
// Register byte offsets (one 32-bit word each)
`define OFF_CMD 8'h00
`define OFF_ACC 8'h04
`define OFF_XREG 8'h08
`define OFF_PSW 8'h0c
`define OFF_IREQ 8'h10
`define OFF_PDIR 8'h14
`define OFF_CLKMODE 8'h18
`define OFF_INFO 8'h1c
`define OFF_MEMX 8'h20

// ==========================================================
// Processor status word bit positions
`define FL_C 0
`define FL_Z 1
`define FL_I 2
`define FL_D 3
`define FL_B 4
`define FL_T 5
`define FL_V 6
`define FL_N 7

// ==========================================================
// Reset values
`define PSW_RST 8'h04
`define ACC_RST 8'h00
`define IREQ_RST 8'h00
`define PDIR_RST 8'h00
`define CLKMODE_RST 1'b0

// ==========================================================
// Instruction codes written to the command register
`define OP_NOP 4'h0
`define OP_ADC 4'h1
`define OP_SBC 4'h2
`define OP_SEC 4'h3
`define OP_CLC 4'h4
`define OP_CLD 4'h5
`define OP_SED 4'h6
`define OP_SEI 4'h7
`define OP_CLI 4'h8
`define OP_SET 4'h9
`define OP_CLT 4'ha
`define OP_MUL 4'hb
`define OP_DIV 4'hc
`define OP_BBS 4'hd
`define OP_BBC 4'he
`define OP_LDM 4'hf

// ==========================================================
// Instruction lengths in internal-clock cycles
`define CYC_ALU 5'h02
`define CYC_MUL 5'h0f
`define CYC_DIV 5'h10
`define CYC_BIT 5'h05
`define CYC_LDM 5'h04

// ==========================================================
// Internal clock division from the main clock
`define DIV_MIDDLE 8
`define DIV_HIGH 2

// ==========================================================
// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- phi_divider.v
// Internal clock generator: one-cycle tick per internal clock period.
// Assumes CLK stands for the main oscillator; the mode input is a level.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_flag_map.vh"

module phi_divider #(
   parameter MIDDLE_RATIO = `DIV_MIDDLE,
   parameter HIGH_RATIO = `DIV_HIGH
) (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Mode select: 1 selects high-speed
   input wire high_speed,
   // One pulse per internal clock period
   output reg phi_tick
);

   // Full-width terminal counts, cut to the counter width on purpose
   localparam [31:0] MID_FULL = MIDDLE_RATIO - 1;
   localparam [31:0] HIGH_FULL = HIGH_RATIO - 1;
   localparam [3:0] LAST_MID = MID_FULL[3:0];
   localparam [3:0] LAST_HIGH = HIGH_FULL[3:0];

   reg [3:0] count;
   wire [3:0] last = high_speed ? LAST_HIGH : LAST_MID;

   // ==========================================================
   // Divider; a mode change takes effect at once, in the period under way
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= 4'h0;
         phi_tick <= 1'b0;
      end else if (count >= last) begin
         count <= 4'h0;
         phi_tick <= 1'b1;
      end else begin
         count <= count + 4'h1;
         phi_tick <= 1'b0;
      end
   end

endmodule // phi_divider
`default_nettype wire

//--- flag_alu.v
// Combinational arithmetic: binary and decimal add/subtract, multiply, divide.
// Assumes the caller decides which flags to keep from these results.
`timescale 1ns/1ns
`default_nettype none

module flag_alu (
   // Operands
   input wire [7:0] a,
   input wire [7:0] b,
   input wire carry_in,
   // Mode: decimal adjust and subtract
   input wire decimal,
   input wire sub,
   // Add/subtract results
   output reg [7:0] sum,
   output reg carry_out,
   output reg overflow,
   // Multiply and divide results, never decimal
   output wire [15:0] product,
   output wire [7:0] quotient,
   output wire [7:0] remainder
);

   reg [8:0] bin;
   reg [4:0] nib;
   reg cy;
   reg [7:0] bb;
   integer i;

   // ==========================================================
   // Add with carry / subtract with borrow (carry set means no borrow)
   always @* begin
      bb = sub ? ~b : b;
      bin = {1'b0, a} + {1'b0, bb} + {8'h00, carry_in};
      sum = bin[7:0];
      carry_out = bin[8];
      overflow = (a[7] == bb[7]) && (bin[7] != a[7]);
      nib = 5'h00;
      cy = carry_in;
      if (decimal) begin
         // Nibble-wise BCD adjust
         for (i = 0; i < 2; i = i + 1) begin
            if (!sub) begin
               nib = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, cy};
               cy = (nib > 5'h09);
               if (cy)
                  nib = nib + 5'h06;
            end else begin
               nib = {1'b0, a[i*4 +: 4]} - {1'b0, b[i*4 +: 4]} - {4'h0, ~cy};
               cy = ~nib[4];
               if (!cy)
                  nib = nib - 5'h06;
            end
            sum[i*4 +: 4] = nib[3:0];
         end
         carry_out = cy;
      end
   end

   // ==========================================================
   // Multiply and divide; divide by zero gives all ones and keeps a
   assign product = {8'h00, a} * {8'h00, b};
   assign quotient = (b == 8'h00) ? 8'hff : a / b;
   assign remainder = (b == 8'h00) ? a : a % b;

endmodule // flag_alu
`default_nettype wire

//--- flag_core_top.v
// Status-flag core with AXI4-Lite register access.
// Assumes CLK is the main oscillator and all inputs are synchronous to it.
//
// Overview of operation
// - Reset sets the interrupt-disable flag; other flags carry no promised value.
// - A written request register takes effect only once another instruction completes.
// - With the decimal flag set, add and subtract work in BCD.
// - Carry results of decimal arithmetic need one instruction before carry/decimal ops.
// - In decimal mode only carry is meaningful; negative, overflow and zero are not.
// - Multiply and divide ignore the index-X-mode and decimal flags.
// - Multiply and divide leave the whole status word unchanged.
// - Port direction registers are write-only and set only by stores.
// - Instruction time is its cycle count times the internal clock period.
// - Out of reset the internal clock is the main clock divided by eight.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_flag_map.vh"

module flag_core_top #(
   parameter ADDR_W = 8
) (
   // Clock and reset
   input wire CLK,
   input wire RST_B,
   // AXI4-Lite write address
   input wire [ADDR_W-1:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   // AXI4-Lite write data
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   // AXI4-Lite write response
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   // AXI4-Lite read address
   input wire [ADDR_W-1:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   // AXI4-Lite read data
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // Interrupt request events from peripherals
   input wire [7:0] IRQ_EVENT,
   // Port direction and core state
   output reg [7:0] PORT_DIR,
   output wire BUSY
);

   // ==========================================================
   // Decoding shared by the read and write paths
   function reg_known;
      input [7:0] addr;
      begin
         case (addr)
            `OFF_CMD, `OFF_ACC, `OFF_XREG, `OFF_PSW, `OFF_IREQ,
            `OFF_PDIR, `OFF_CLKMODE, `OFF_INFO, `OFF_MEMX: reg_known = 1'b1;
            default: reg_known = 1'b0;
         endcase
      end
   endfunction

   // Registers that refuse bus writes while an instruction is running
   function busy_locked;
      input [7:0] addr;
      begin
         case (addr)
            `OFF_CMD, `OFF_ACC, `OFF_XREG, `OFF_PSW, `OFF_MEMX: busy_locked = 1'b1;
            default: busy_locked = 1'b0;
         endcase
      end
   endfunction

   // Cycle count of each instruction
   function [4:0] op_cycles;
      input [3:0] op;
      begin
         case (op)
            `OP_MUL: op_cycles = `CYC_MUL;
            `OP_DIV: op_cycles = `CYC_DIV;
            `OP_BBS, `OP_BBC: op_cycles = `CYC_BIT;
            `OP_LDM: op_cycles = `CYC_LDM;
            default: op_cycles = `CYC_ALU;
         endcase
      end
   endfunction

   // ==========================================================
   // Core state
   reg [7:0] acc;
   reg [7:0] xreg;
   reg [7:0] memx;
   reg [7:0] psw;
   reg [7:0] ireq;
   reg [7:0] ireq_stage;
   reg stage_valid;
   reg clk_high;
   reg busy;
   reg [3:0] cur_op;
   reg [7:0] operand;
   reg [4:0] cycles_left;
   reg taken;
   reg dec_recent;
   reg dec_hazard;

   // Bus state
   reg aw_held;
   reg [7:0] aw_addr;
   reg w_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   wire phi_tick;
   wire [7:0] alu_sum;
   wire alu_c;
   wire alu_v;
   wire [15:0] product;
   wire [7:0] quotient;
   wire [7:0] remainder;

   // Operate on memory at X instead of the accumulator when T is set
   wire use_memx = psw[`FL_T];
   wire is_arith = (cur_op == `OP_ADC) || (cur_op == `OP_SBC);
   // Multiply and divide always take the accumulator, whatever T holds
   wire [7:0] alu_a = (use_memx && is_arith) ? memx : acc;
   wire dec_mode = psw[`FL_D] & is_arith;
   wire commit = busy && phi_tick && (cycles_left == 5'h01);

   // ==========================================================
   // Internal clock; middle speed after reset
   phi_divider #(
      .MIDDLE_RATIO(`DIV_MIDDLE),
      .HIGH_RATIO(`DIV_HIGH)
   ) u_phi (
      .clk(CLK),
      .rst_b(RST_B),
      .high_speed(clk_high),
      .phi_tick(phi_tick)
   );

   // ==========================================================
   // Arithmetic unit
   flag_alu u_alu (
      .a(alu_a),
      .b(operand),
      .carry_in(psw[`FL_C]),
      .decimal(dec_mode),
      .sub(cur_op == `OP_SBC),
      .sum(alu_sum),
      .carry_out(alu_c),
      .overflow(alu_v),
      .product(product),
      .quotient(quotient),
      .remainder(remainder)
   );

   // ==========================================================
   // AXI4-Lite handshakes; address and data may arrive in any order
   assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   assign BUSY = busy;

   wire do_write = aw_held && w_held && !S_AXI_BVALID;
   wire wr_ok = reg_known(aw_addr) && !(busy && busy_locked(aw_addr));
   wire wr_en = do_write && wr_ok && w_strb[0];
   wire wr_cmd = wr_en && (aw_addr == `OFF_CMD);

   // Address and data capture, write response
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR[7:0];
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // Read path; one cycle from address to data
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP <= reg_known(S_AXI_ARADDR[7:0]) ? `RESP_OKAY : `RESP_SLVERR;
         case (S_AXI_ARADDR[7:0])
            `OFF_CMD: S_AXI_RDATA <= {16'h0000, operand, 4'h0, cur_op};
            `OFF_ACC: S_AXI_RDATA <= {24'h000000, acc};
            `OFF_XREG: S_AXI_RDATA <= {24'h000000, xreg};
            `OFF_PSW: S_AXI_RDATA <= {24'h000000, psw};
            `OFF_IREQ: S_AXI_RDATA <= {24'h000000, ireq};
            `OFF_CLKMODE: S_AXI_RDATA <= {31'h00000000, clk_high};
            `OFF_INFO: S_AXI_RDATA <= {26'h0000000, stage_valid, cycles_left == 5'h00,
                                       dec_recent, dec_hazard, taken, busy};
            `OFF_MEMX: S_AXI_RDATA <= {24'h000000, memx};
            // Direction register never reads back
            default: S_AXI_RDATA <= 32'h00000000;
         endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // ==========================================================
   // Instruction sequencing and register updates
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         acc <= `ACC_RST;
         xreg <= `ACC_RST;
         memx <= `ACC_RST;
         psw <= `PSW_RST;
         ireq <= `IREQ_RST;
         ireq_stage <= `IREQ_RST;
         stage_valid <= 1'b0;
         PORT_DIR <= `PDIR_RST;
         clk_high <= `CLKMODE_RST;
         busy <= 1'b0;
         cur_op <= `OP_NOP;
         operand <= 8'h00;
         cycles_left <= 5'h00;
         taken <= 1'b0;
         dec_recent <= 1'b0;
         dec_hazard <= 1'b0;
      end else begin
         // Peripheral events always land, also in a staged value
         ireq <= ireq | IRQ_EVENT;
         ireq_stage <= ireq_stage | IRQ_EVENT;

         // Software writes
         if (wr_en) begin
            case (aw_addr)
               `OFF_ACC: acc <= w_data[7:0];
               `OFF_XREG: xreg <= w_data[7:0];
               `OFF_MEMX: memx <= w_data[7:0];
               `OFF_PSW: psw <= w_data[7:0];
               `OFF_PDIR: PORT_DIR <= w_data[7:0];
               `OFF_CLKMODE: clk_high <= w_data[0];
               `OFF_IREQ: begin
                  // Held back until an instruction completes
                  ireq_stage <= w_data[7:0] | IRQ_EVENT;
                  stage_valid <= 1'b1;
               end
               `OFF_INFO: begin
                  if (w_data[2])
                     dec_hazard <= 1'b0;
               end
               default: begin
               end
            endcase
         end
         if (wr_cmd) begin
            cur_op <= w_data[3:0];
            operand <= w_data[15:8];
            cycles_left <= op_cycles(w_data[3:0]);
            busy <= 1'b1;
         end

         // Count internal clock periods
         if (busy && phi_tick && !commit)
            cycles_left <= cycles_left - 5'h01;

         // Completion of an instruction
         if (commit) begin
            busy <= 1'b0;
            cycles_left <= 5'h00;
            // Staged request bits become visible after this instruction
            if (stage_valid && !(wr_en && aw_addr == `OFF_IREQ)) begin
               ireq <= ireq_stage | IRQ_EVENT;
               stage_valid <= 1'b0;
            end
            // Decimal carry still settling; flag a too-early carry op
            if (dec_recent && ((cur_op == `OP_SEC) || (cur_op == `OP_CLC) ||
                               (cur_op == `OP_CLD)))
               dec_hazard <= 1'b1;
            dec_recent <= is_arith && psw[`FL_D];
            case (cur_op)
               `OP_ADC, `OP_SBC: begin
                  if (use_memx)
                     memx <= alu_sum;
                  else
                     acc <= alu_sum;
                  psw[`FL_C] <= alu_c;
                  // Decimal mode leaves N, V and Z untouched
                  if (!psw[`FL_D]) begin
                     psw[`FL_N] <= alu_sum[7];
                     psw[`FL_V] <= alu_v;
                     psw[`FL_Z] <= (alu_sum == 8'h00);
                  end
               end
               `OP_SEC: psw[`FL_C] <= 1'b1;
               `OP_CLC: psw[`FL_C] <= 1'b0;
               `OP_CLD: psw[`FL_D] <= 1'b0;
               `OP_SED: psw[`FL_D] <= 1'b1;
               `OP_SEI: psw[`FL_I] <= 1'b1;
               `OP_CLI: psw[`FL_I] <= 1'b0;
               `OP_SET: psw[`FL_T] <= 1'b1;
               `OP_CLT: psw[`FL_T] <= 1'b0;
               // Always on the accumulator, status word untouched
               `OP_MUL: begin
                  acc <= product[7:0];
                  xreg <= product[15:8];
               end
               `OP_DIV: begin
                  acc <= quotient;
                  xreg <= remainder;
               end
               // Bit test sees the request bits in force before any staged write
               `OP_BBS: taken <= ireq[operand[2:0]];
               `OP_BBC: taken <= ~ireq[operand[2:0]];
               // Immediate store into the direction register
               `OP_LDM: PORT_DIR <= operand;
               default: begin
               end
            endcase
         end
      end
   end

endmodule // flag_core_top
`default_nettype wire

//--- flag_core_checker.sv
// Checker for flag_core_top: bus handshakes, busy length, port direction.
// Assumes it is bound to flag_core_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_flag_map.vh"
module flag_core_checker #(
   parameter ADDR_W = 8
) (
   // Clock and reset
   input wire CLK,
   input wire RST_B,
   // Bus channels
   input wire [ADDR_W-1:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire S_AXI_WVALID,
   input wire S_AXI_WREADY,
   input wire [1:0] S_AXI_BRESP,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [ADDR_W-1:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // Core outputs
   input wire [7:0] PORT_DIR,
   input wire BUSY
);
   // ====
   // One clock domain, checks switched off while reset is held
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // Write with both halves taken in one cycle
   sequence wr_take;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   // Same, aimed past the last register
   sequence wr_bad;
      wr_take ##0 (S_AXI_AWADDR > 8'h23);
   endsequence
   sequence b_err;
      S_AXI_BVALID && S_AXI_BRESP == `RESP_SLVERR;
   endsequence
   // ====
   // Assertions
   a_b_hold: assert property (
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   a_r_hold: assert property (
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped early");
   a_w_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write accepted during response");
   a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read accepted during response");
   a_b_latency: assert property (wr_take |-> ##[1:2] S_AXI_BVALID)
      else $error("write response late");
   a_bad_wr: assert property (wr_bad |-> ##[1:2] b_err)
      else $error("unmapped write not refused");
   a_pdir_read: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `OFF_PDIR
      |=> S_AXI_RVALID && S_AXI_RDATA == 32'h0) else $error("direction register readable");
   a_busy_min: assert property ($rose(BUSY) |-> BUSY [*3])
      else $error("instruction too short");
   a_busy_max: assert property ($rose(BUSY) |-> ##[1:130] !BUSY)
      else $error("instruction too long");
   a_pdir_cause: assert property (
      $changed(PORT_DIR) |-> $past(BUSY) || S_AXI_BVALID)
      else $error("direction changed without store");
endmodule // flag_core_checker
`default_nettype wire

//--- flag_core_tb_top.sv
// Testbench for flag_core_top: bus tasks and one task per scenario.
// Assumes the design files and cpu_flag_map.vh are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_flag_map.vh"
module flag_core_tb_top;
   logic clk;
   logic rst_b = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, irq = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   wire awready, wready, bvalid, arready, rvalid, busy;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] port_dir;
   logic [7:0] blen = 8'h00, last_len = 8'h00;
   int n_errors = 0, checks = 0;

   flag_core_top uut (.CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .IRQ_EVENT(irq), .PORT_DIR(port_dir), .BUSY(busy));

   // 25 MHz main clock
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   // Length of the last busy stretch, in main clock cycles
   always @(posedge clk) begin
      if (busy) blen <= blen + 8'h01;
      else if (blen != 8'h00) begin
         last_len <= blen;
         blen <= 8'h00;
      end
   end

   // ====
   // Reporting
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic hung;
      n_errors++;
      $display("Error at %0t ns: no answer", $time);
      stop_test;
   endtask

   // ====
   // Bus master; answer ready raised with the request and held until valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end while (!(bvalid && bready) && n < 50);
      if (n >= 50) hung;
      r = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      n = 0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!(rvalid && rready) && n < 50);
      if (n >= 50) hung;
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask
   task automatic wrs(input logic [7:0] a, input logic [7:0] v);
      logic [1:0] r;
      wr(a, {24'h0, v}, r);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      check(d & m, e);
   endtask
   // Wait for the core to finish; a command sent while busy is refused
   task automatic idle;
      int n;
      n = 0;
      while (busy !== 1'h1 && n < 4) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (busy !== 1'h0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) hung;
      repeat (2) @(posedge clk);
   endtask
   task automatic run(input logic [3:0] op, input logic [7:0] v);
      logic [1:0] r;
      wr(`OFF_CMD, {16'h0, v, 4'h0, op}, r);
      idle;
   endtask
   task automatic tlen(input logic [3:0] op, input int cyc, input int k);
      run(op, 8'h01);
      check({31'h0, last_len >= cyc * k - k + 1 && last_len <= cyc * k}, 32'h1);
   endtask

   // ====
   // Scenarios
   task automatic t_decimal;
      wrs(`OFF_PSW, 8'h08);
      wrs(`OFF_ACC, 8'h99);
      run(`OP_ADC, 8'h01);
      rdchk(`OFF_ACC, 32'hff, 32'h00);
      rdchk(`OFF_PSW, 32'h01, 32'h01);
      run(`OP_SBC, 8'h01);
      rdchk(`OFF_ACC, 32'hff, 32'h99);
      rdchk(`OFF_PSW, 32'h01, 32'h00);
      wrs(`OFF_PSW, 8'h01);
      wrs(`OFF_ACC, 8'h45);
      run(`OP_ADC, 8'h38);
      rdchk(`OFF_ACC, 32'hff, 32'h7e);
      $display("decimal test done");
   endtask
   task automatic t_hazard;
      logic [11:0] ops;
      ops = {`OP_SEC, `OP_CLC, `OP_CLD};
      for (int i = 0; i < 4; i++) begin
         wrs(`OFF_PSW, 8'h09);
         wrs(`OFF_INFO, 8'h04);
         run(`OP_ADC, 8'h01);
         if (i == 3) run(`OP_NOP, 8'h00);
         run(i == 3 ? `OP_CLC : ops[4 * i +: 4], 8'h00);
         rdchk(`OFF_INFO, 32'h4, i == 3 ? 32'h0 : 32'h4);
      end
      rdchk(`OFF_PSW, 32'h1, 32'h0);
      $display("hazard test done");
   endtask
   // Operands chosen so binary and BCD answers differ
   task automatic t_muldiv;
      wrs(`OFF_PSW, 8'h28);
      wrs(`OFF_ACC, 8'h15);
      run(`OP_MUL, 8'h09);
      rdchk(`OFF_ACC, 32'hff, 32'hbd);
      rdchk(`OFF_XREG, 32'hff, 32'h00);
      rdchk(`OFF_PSW, 32'hff, 32'h28);
      wrs(`OFF_PSW, 8'hcb);
      wrs(`OFF_ACC, 8'h64);
      run(`OP_DIV, 8'h07);
      rdchk(`OFF_ACC, 32'hff, 32'h0e);
      rdchk(`OFF_XREG, 32'hff, 32'h02);
      rdchk(`OFF_PSW, 32'hff, 32'hcb);
      $display("multiply test done");
   endtask
   task automatic t_ireq;
      wrs(`OFF_IREQ, 8'h08);
      run(`OP_BBS, 8'h03);
      rdchk(`OFF_INFO, 32'h2, 32'h0);
      run(`OP_BBS, 8'h03);
      rdchk(`OFF_INFO, 32'h2, 32'h2);
      run(`OP_BBC, 8'h03);
      rdchk(`OFF_INFO, 32'h2, 32'h0);
      irq <= 8'h20;
      @(posedge clk);
      irq <= 8'h00;
      run(`OP_BBS, 8'h05);
      rdchk(`OFF_INFO, 32'h2, 32'h2);
      $display("request test done");
   endtask
   task automatic t_misc;
      logic [31:0] d;
      logic [1:0] r;
      run(`OP_LDM, 8'ha5);
      check({24'h0, port_dir}, 32'ha5);
      rdchk(`OFF_PDIR, 32'hffffffff, 32'h0);
      wrs(`OFF_PDIR, 8'h3c);
      check({24'h0, port_dir}, 32'h3c);
      wr(8'h40, 32'h1, r);
      check({30'h0, r}, {30'h0, `RESP_SLVERR});
      rd(8'h40, d, r);
      check({d[29:0], r}, {30'h0, `RESP_SLVERR});
      wrs(`OFF_ACC, 8'h03);
      wr(`OFF_CMD, {16'h0, 8'h02, 4'h0, `OP_MUL}, r);
      wr(`OFF_ACC, 32'h55, r);
      check({30'h0, r}, {30'h0, `RESP_SLVERR});
      idle;
      rdchk(`OFF_ACC, 32'hff, 32'h06);
      $display("port and refusal test done");
   endtask
   task automatic t_timing;
      tlen(`OP_MUL, `CYC_MUL, `DIV_MIDDLE);
      tlen(`OP_DIV, `CYC_DIV, `DIV_MIDDLE);
      wrs(`OFF_CLKMODE, 8'h01);
      tlen(`OP_MUL, `CYC_MUL, `DIV_HIGH);
      tlen(`OP_LDM, `CYC_LDM, `DIV_HIGH);
      tlen(`OP_NOP, `CYC_ALU, `DIV_HIGH);
      $display("timing test done");
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'h1;
      rdchk(`OFF_PSW, 32'h4, 32'h4);
      rdchk(`OFF_CLKMODE, 32'h1, 32'h0);
      t_decimal;
      t_hazard;
      t_muldiv;
      t_ireq;
      t_misc;
      t_timing;
      stop_test;
   end
endmodule // flag_core_tb_top

bind flag_core_top flag_core_checker #(.ADDR_W(ADDR_W)) chk (.CLK(CLK), .RST_B(RST_B),
   .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .PORT_DIR(PORT_DIR), .BUSY(BUSY));
`default_nettype wire
